//--- dhp_pkg.sv
// dhp_pkg: constants shared by the dsp ram host access port
// assumes a 50 MHz system clock and byte-wide registers on a 32-bit bus
package dhp_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int SAMPLE_HZ = 9600;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int REG_W = 8;
   localparam int IDX_W = 6;
   localparam int BUS_AW = 8;
   localparam int BUS_DW = 32;
   localparam int WORD_W = 16;
   localparam int RAM_AW = 7;

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [3:0] SUB_IMAG_LO = 4'h0;
   localparam logic [3:0] SUB_IMAG_HI = 4'h1;
   localparam logic [3:0] SUB_REAL_LO = 4'h2;
   localparam logic [3:0] SUB_REAL_HI = 4'h3;
   localparam logic [3:0] SUB_RAM_ADDR = 4'h4;
   localparam logic [3:0] SUB_CTRL = 4'h5;
   localparam logic [3:0] SUB_PAR_CTRL = 4'h8;
   localparam logic [3:0] SUB_PINT_CTRL = 4'h9;
   localparam logic [3:0] SUB_PINT_SEL = 4'ha;
   localparam logic [3:0] SUB_PINT_MASK = 4'hb;
   localparam logic [IDX_W-1:0] IDX_PAR_BUF = 6'h10;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CB_REQ = 0;
   localparam int CB_WR = 1;
   localparam int CB_COEF = 2;
   localparam int CB_RATE = 3;
   localparam int CB_IE = 4;
   localparam int CB_RDY = 5;
   localparam int CB_FLAG = 6;
   localparam int ADDR_BANK_BIT = 7;
   localparam int PC_EN = 0;
   localparam int PC_TX = 1;
   localparam int PI_EN = 0;
   localparam int PI_LOGIC = 1;
   localparam int PI_TRIG_LO = 2;
   localparam int PI_TRIG_HI = 3;
   localparam int PI_PEND = 4;
   localparam int PI_ACT = 5;

   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [REG_W-1:0] REG_RST = 8'h00;
   localparam logic [2:0] BIT_CNT_MAX = 3'h7;

   typedef enum logic [1:0] {
      TRIG_TRUE = 2'h0,
      TRIG_FALSE = 2'h1,
      TRIG_RISE = 2'h2,
      TRIG_FALL = 2'h3
   } dhp_trig_type;

endpackage

//--- dhp_dsp_ram.sv
// dhp_dsp_ram: the four dsp ram banks reached through the host port
// assumes one access per cycle from the port logic on the same clock
`timescale 1ns/1ps
module dhp_dsp_ram
   import dhp_pkg::*;
#(
   parameter int AW = RAM_AW,
   parameter int DW = WORD_W
)
(
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic coef_i,
   input wire logic imag_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   output logic [DW-1:0] real_o,
   output logic [DW-1:0] imag_o
);

   logic [DW-1:0] data_real [2**AW];
   logic [DW-1:0] data_imag [2**AW];
   logic [DW-1:0] coef_real [2**AW];
   logic [DW-1:0] coef_imag [2**AW];

   // ----------------------------------------------------------------
   // read both banks of the chosen ram at once
   // ----------------------------------------------------------------
   assign real_o = coef_i ? coef_real[addr_i] : data_real[addr_i];
   assign imag_o = coef_i ? coef_imag[addr_i] : data_imag[addr_i];

   // ----------------------------------------------------------------
   // single word write into one bank
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         case ({coef_i, imag_i})
            2'h0: data_real[addr_i] <= wdata_i;
            2'h1: data_imag[addr_i] <= wdata_i;
            2'h2: coef_real[addr_i] <= wdata_i;
            default: coef_imag[addr_i] <= wdata_i;
         endcase
      end
   end

endmodule

//--- dhp_host_port.sv
// dhp_host_port: host register window onto dsp ram, parallel byte buffer
// and programmable interrupt, reached over avalon-mm with waitrequest
// assumes baud_tick_i, bit_tick_i and rx_bit_i come from logic on clk_i
//
// Behaviour
// - ram address low seven bits pick location, bit seven picks imag bank
// - rate select chooses baud or sample period pacing of each transfer
// - coef select low uses data ram, high uses coefficient ram
// - parallel mode leaves only channel one, index 10h becomes byte buffer
// - a ram read moves real and imag words into four data registers
// - completion sets ready and flag, interrupt if interrupt enable set
// - reading imag low clears flag and ready, interrupt drops if idle
// - a ram write moves one word from imag data registers into a bank
// - after a write, reading or writing imag low clears flag and ready
// - receive mode stores a byte every eight bits, host read clears ready
// - unread receive byte is overwritten by the next one
// - received byte holds oldest bit in bit zero, newest in bit seven
// - transmit mode fetches buffer every eight bits, host write clears ready
// - buffer not refilled in time is sent again
// - transmit sends bit zero first and bit seven last
// - programmable interrupt is evaluated once per 9600 Hz sample period
// - enabled condition sets pending, drives irq low, only host clears it
// - condition tests masked bits of one selected interface register
// - masked bits combine by and or or, with four trigger options
// - access request is sampled once per baud or sample period
`timescale 1ns/1ps
module dhp_host_port
   import dhp_pkg::*;
#(
   parameter int SAMPLE_DIV = SAMPLE_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [BUS_AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [BUS_DW-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [BUS_DW-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic baud_tick_i,
   input wire logic bit_tick_i,
   input wire logic rx_bit_i,
   output logic tx_bit_o,
   output logic irq_n_o
);

   localparam int CNT_W = $clog2(SAMPLE_DIV);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] samp_cnt_r;
   logic samp_tick;
   logic ack_r;
   logic [REG_W-1:0] rdata_r;
   logic [IDX_W-1:0] idx;
   logic rd_acc;
   logic wr_acc;
   logic [REG_W-1:0] wdat;
   logic [REG_W-1:0] ram_addr_r [2];
   logic [REG_W-1:0] ilo_r [2];
   logic [REG_W-1:0] ihi_r [2];
   logic [REG_W-1:0] rlo_r [2];
   logic [REG_W-1:0] rhi_r [2];
   logic [1:0] req_r;
   logic [1:0] wr_r;
   logic [1:0] coef_r;
   logic [1:0] rate_r;
   logic [1:0] ie_r;
   logic [1:0] rdy_r;
   logic [1:0] flag_r;
   logic [1:0] due_r;
   logic [1:0] ch_tick;
   logic [1:0] serve;
   logic [1:0] set_rdy;
   logic [1:0] clr_rdy;
   logic ram_ch;
   logic [WORD_W-1:0] ram_real;
   logic [WORD_W-1:0] ram_imag;
   logic par_en_r;
   logic par_tx_r;
   logic [REG_W-1:0] buf_r;
   logic [REG_W-1:0] shift_r;
   logic [2:0] bit_cnt_r;
   logic par_evt;
   logic par_clr;
   logic pi_en_r;
   logic pi_or_r;
   dhp_trig_type pi_trig_r;
   logic pi_pend_r;
   logic pi_act_r;
   logic [IDX_W-1:0] pi_sel_r;
   logic [REG_W-1:0] pi_mask_r;
   logic [REG_W-1:0] pi_masked;
   logic pi_cond;
   logic pi_prev_r;
   logic pi_hit;
   logic pi_fire;
   logic irq_n_r;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // true when i is the index of register sub within channel ch
   function automatic logic hit(input logic [IDX_W-1:0] i, input int ch,
                                input logic [3:0] sub);
      hit = (i == {1'b0, ch[0], sub});
   endfunction

   // register contents as software and the interrupt tester see them
   function automatic logic [REG_W-1:0] reg_view(input logic [IDX_W-1:0] i);
      logic c;
      c = i[4];
      reg_view = REG_RST;
      if (!i[5])
      begin
         case (i[3:0])
            SUB_IMAG_LO: reg_view = (c && par_en_r) ? buf_r : ilo_r[c];
            SUB_IMAG_HI: reg_view = ihi_r[c];
            SUB_REAL_LO: reg_view = rlo_r[c];
            SUB_REAL_HI: reg_view = rhi_r[c];
            SUB_RAM_ADDR: reg_view = ram_addr_r[c];
            SUB_CTRL:
            begin
               reg_view[CB_REQ] = req_r[c];
               reg_view[CB_WR] = wr_r[c];
               reg_view[CB_COEF] = coef_r[c];
               reg_view[CB_RATE] = rate_r[c];
               reg_view[CB_IE] = ie_r[c];
               reg_view[CB_RDY] = rdy_r[c];
               reg_view[CB_FLAG] = flag_r[c];
            end
            SUB_PAR_CTRL:
            begin
               reg_view[PC_EN] = !c && par_en_r;
               reg_view[PC_TX] = !c && par_tx_r;
            end
            SUB_PINT_CTRL:
            begin
               reg_view[PI_EN] = !c && pi_en_r;
               reg_view[PI_LOGIC] = !c && pi_or_r;
               reg_view[PI_TRIG_HI:PI_TRIG_LO] = c ? 2'h0 : pi_trig_r;
               reg_view[PI_PEND] = !c && pi_pend_r;
               reg_view[PI_ACT] = !c && pi_act_r;
            end
            SUB_PINT_SEL: reg_view = c ? REG_RST : {2'h0, pi_sel_r};
            SUB_PINT_MASK: reg_view = c ? REG_RST : pi_mask_r;
            default: reg_view = REG_RST;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // sample period tick at 9600 Hz
   // ----------------------------------------------------------------
   assign samp_tick = (samp_cnt_r == CNT_W'(SAMPLE_DIV - 1));

   always_ff @(posedge clk_i)
   begin
      if (rst_i || samp_tick)
         samp_cnt_r <= '0;
      else
         samp_cnt_r <= samp_cnt_r + 1'b1;
   end

   // ----------------------------------------------------------------
   // avalon slave: one wait cycle, access takes effect when released
   // ----------------------------------------------------------------
   assign idx = avs_address_i[BUS_AW-1:2];
   assign wdat = avs_writedata_i[REG_W-1:0];
   assign rd_acc = avs_read_i && ack_r;
   assign wr_acc = avs_write_i && ack_r && avs_byteenable_i[0];
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
   assign avs_readdata_o = {{(BUS_DW - REG_W){1'b0}}, rdata_r};

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
         rdata_r <= REG_RST;
      end
      else
      begin
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
         if (avs_read_i && !ack_r)
            rdata_r <= reg_view(idx); // unmapped reads give zero
      end
   end

   // ----------------------------------------------------------------
   // channel setup registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      for (int c = 0; c < 2; c++)
      begin
         if (rst_i)
         begin
            ram_addr_r[c] <= REG_RST;
            req_r[c] <= 1'b0;
            wr_r[c] <= 1'b0;
            coef_r[c] <= 1'b0;
            rate_r[c] <= 1'b0;
            ie_r[c] <= 1'b0;
         end
         else if (wr_acc && hit(idx, c, SUB_RAM_ADDR))
            ram_addr_r[c] <= wdat;
         else if (wr_acc && hit(idx, c, SUB_CTRL))
         begin
            req_r[c] <= wdat[CB_REQ];
            wr_r[c] <= wdat[CB_WR];
            coef_r[c] <= wdat[CB_COEF];
            rate_r[c] <= wdat[CB_RATE];
            ie_r[c] <= wdat[CB_IE];
         end
      end
   end

   // ----------------------------------------------------------------
   // request sampling and service, channel one first
   // ----------------------------------------------------------------
   assign serve[0] = due_r[0];
   assign serve[1] = due_r[1] && !due_r[0];

   always_comb
   begin
      for (int c = 0; c < 2; c++)
         ch_tick[c] = rate_r[c] ? baud_tick_i : samp_tick;
   end

   always_ff @(posedge clk_i)
   begin
      for (int c = 0; c < 2; c++)
      begin
         if (rst_i)
            due_r[c] <= 1'b0;
         else if (serve[c])
            due_r[c] <= 1'b0; // served first so a tick in the same cycle cannot repeat it
         else if (ch_tick[c] && req_r[c] && !rdy_r[c] && !(c == 1 && par_en_r))
            due_r[c] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // dsp ram access
   // ----------------------------------------------------------------
   assign ram_ch = serve[1];

   dhp_dsp_ram #(
      .AW(RAM_AW),
      .DW(WORD_W)
   ) u_ram (
      .clk_i(clk_i),
      .we_i(|(serve & wr_r)),
      .coef_i(coef_r[ram_ch]),
      .imag_i(ram_addr_r[ram_ch][ADDR_BANK_BIT]),
      .addr_i(ram_addr_r[ram_ch][RAM_AW-1:0]),
      .wdata_i({ihi_r[ram_ch], ilo_r[ram_ch]}),
      .real_o(ram_real),
      .imag_o(ram_imag)
   );

   // ----------------------------------------------------------------
   // data registers: ram read loads all four, host loads the rest
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      for (int c = 0; c < 2; c++)
      begin
         if (rst_i)
         begin
            ilo_r[c] <= REG_RST;
            ihi_r[c] <= REG_RST;
            rlo_r[c] <= REG_RST;
            rhi_r[c] <= REG_RST;
         end
         else if (serve[c] && !wr_r[c])
         begin
            rhi_r[c] <= ram_real[WORD_W-1:REG_W];
            rlo_r[c] <= ram_real[REG_W-1:0];
            ihi_r[c] <= ram_imag[WORD_W-1:REG_W];
            ilo_r[c] <= ram_imag[REG_W-1:0];
         end
         else if (wr_acc)
         begin
            if (hit(idx, c, SUB_IMAG_LO) && !(c == 1 && par_en_r))
               ilo_r[c] <= wdat;
            if (hit(idx, c, SUB_IMAG_HI))
               ihi_r[c] <= wdat;
            if (hit(idx, c, SUB_REAL_LO))
               rlo_r[c] <= wdat;
            if (hit(idx, c, SUB_REAL_HI))
               rhi_r[c] <= wdat;
         end
      end
   end

   // ----------------------------------------------------------------
   // completion flags: set wins over clear
   // ----------------------------------------------------------------
   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         set_rdy[c] = serve[c] || (c == 1 && par_evt);
         clr_rdy[c] = !(c == 1 && par_en_r) && hit(idx, c, SUB_IMAG_LO)
                      && (rd_acc || (wr_acc && wr_r[c]));
         if (c == 1)
            clr_rdy[c] = clr_rdy[c] || par_clr;
      end
   end

   always_ff @(posedge clk_i)
   begin
      for (int c = 0; c < 2; c++)
      begin
         if (rst_i)
         begin
            rdy_r[c] <= 1'b0;
            flag_r[c] <= 1'b0;
         end
         else if (set_rdy[c])
         begin
            rdy_r[c] <= 1'b1;
            flag_r[c] <= 1'b1;
         end
         else if (clr_rdy[c])
         begin
            rdy_r[c] <= 1'b0;
            flag_r[c] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // parallel mode control
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         par_en_r <= 1'b0;
         par_tx_r <= 1'b0;
      end
      else if (wr_acc && hit(idx, 0, SUB_PAR_CTRL))
      begin
         par_en_r <= wdat[PC_EN];
         par_tx_r <= wdat[PC_TX];
      end
   end

   // ----------------------------------------------------------------
   // parallel byte engine, one bit per bit tick
   // ----------------------------------------------------------------
   assign par_evt = par_en_r && bit_tick_i && (bit_cnt_r == BIT_CNT_MAX);
   assign par_clr = par_en_r && (idx == IDX_PAR_BUF)
                    && (par_tx_r ? wr_acc : rd_acc);
   assign tx_bit_o = shift_r[0];

   always_ff @(posedge clk_i)
   begin
      if (rst_i || !par_en_r)
      begin
         bit_cnt_r <= 3'h0;
         shift_r <= REG_RST;
      end
      else if (bit_tick_i)
      begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (!par_tx_r)
            shift_r <= {rx_bit_i, shift_r[REG_W-1:1]};
         else if (bit_cnt_r == BIT_CNT_MAX)
            shift_r <= buf_r;
         else
            shift_r <= {1'b0, shift_r[REG_W-1:1]};
      end
   end

   // byte buffer: device receive store wins over any host write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         buf_r <= REG_RST;
      else if (par_evt && !par_tx_r)
         buf_r <= {rx_bit_i, shift_r[REG_W-1:1]};
      else if (wr_acc && par_en_r && par_tx_r && idx == IDX_PAR_BUF)
         buf_r <= wdat;
   end

   // ----------------------------------------------------------------
   // programmable interrupt configuration
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pi_en_r <= 1'b0;
         pi_or_r <= 1'b0;
         pi_trig_r <= TRIG_TRUE;
         pi_sel_r <= '0;
         pi_mask_r <= REG_RST;
      end
      else if (wr_acc && hit(idx, 0, SUB_PINT_CTRL))
      begin
         pi_en_r <= wdat[PI_EN];
         pi_or_r <= wdat[PI_LOGIC];
         pi_trig_r <= dhp_trig_type'(wdat[PI_TRIG_HI:PI_TRIG_LO]);
      end
      else if (wr_acc && hit(idx, 0, SUB_PINT_SEL))
         pi_sel_r <= wdat[IDX_W-1:0];
      else if (wr_acc && hit(idx, 0, SUB_PINT_MASK))
         pi_mask_r <= wdat;
   end

   // ----------------------------------------------------------------
   // programmable interrupt condition and trigger
   // ----------------------------------------------------------------
   // process form so the view follows every register the function reads
   always_comb
      pi_masked = reg_view(pi_sel_r) & pi_mask_r;
   assign pi_cond = pi_or_r ? (|pi_masked) : (pi_masked == pi_mask_r);

   always_comb
   begin
      case (pi_trig_r)
         TRIG_TRUE: pi_hit = pi_cond;
         TRIG_FALSE: pi_hit = !pi_cond;
         TRIG_RISE: pi_hit = pi_cond && !pi_prev_r;
         TRIG_FALL: pi_hit = !pi_cond && pi_prev_r;
         default: pi_hit = 1'b0;
      endcase
   end

   assign pi_fire = samp_tick && pi_en_r && pi_hit && !pi_pend_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pi_prev_r <= 1'b0;
         pi_act_r <= 1'b0;
      end
      else if (samp_tick)
      begin
         pi_prev_r <= pi_cond;
         pi_act_r <= pi_hit;
      end
   end

   // pending: set by the device, cleared only by a host write of zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pi_pend_r <= 1'b0;
      else if (pi_fire)
         pi_pend_r <= 1'b1;
      else if (wr_acc && hit(idx, 0, SUB_PINT_CTRL))
         pi_pend_r <= pi_pend_r && wdat[PI_PEND];
   end

   // ----------------------------------------------------------------
   // active low interrupt output
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_n_r <= 1'b1;
      else
         irq_n_r <= !(|(flag_r & ie_r) || pi_pend_r);
   end

   assign irq_n_o = irq_n_r;

endmodule

//--- dhp_host_port_props.sv
// dhp_host_port_props: port assertions for the host access port
// assumes it is bound onto dhp_host_port and sees only its ports
`timescale 1ns/1ps
module dhp_host_port_props
   import dhp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [BUS_DW-1:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic bit_tick_i,
   input wire logic tx_bit_o,
   input wire logic irq_n_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   // ----------------------------------------------------------------
   // bus cycle steps
   // ----------------------------------------------------------------
   sequence req_wait;
      (avs_read_i | avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence req_done;
      (avs_read_i | avs_write_i) && !avs_waitrequest_o;
   endsequence
   chk_wait_first: assert property (disable iff (rst_i)
      $rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o)
      else $error("no wait state at start of access");
   chk_one_wait: assert property (disable iff (rst_i) req_wait |=> req_done)
      else $error("more than one wait state");
   chk_upper_zero: assert property (disable iff (rst_i) avs_readdata_o[31:8] == 24'h0)
      else $error("read data upper lanes not zero");
   chk_rdata_hold: assert property (disable iff (rst_i)
      !avs_read_i |=> $stable(avs_readdata_o))
      else $error("read data changed without a read");
   chk_tx_hold: assert property (disable iff (rst_i)
      !bit_tick_i && !avs_write_i |=> $stable(tx_bit_o))
      else $error("tx bit moved without a bit tick");
   chk_irq_release: assert property (disable iff (rst_i)
      $rose(irq_n_o) |-> $past((avs_read_i | avs_write_i) && !avs_waitrequest_o, 2))
      else $error("irq released without a host access");
   chk_irq_reset: assert property (rst_i |=> irq_n_o)
      else $error("irq low after reset");
   chk_tx_reset: assert property (rst_i |=> !tx_bit_o)
      else $error("tx bit high after reset");
endmodule
bind dhp_host_port dhp_host_port_props props_i (.clk_i(clk_i), .rst_i(rst_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .bit_tick_i(bit_tick_i), .tx_bit_o(tx_bit_o),
   .irq_n_o(irq_n_o));

//--- dhp_host_model.sv
// dhp_host_model: host processor side, one avalon-mm access at a time
// assumes waitrequest and read data come from the port on clk_i
`timescale 1ns/1ps
module dhp_host_model
   import dhp_pkg::*;
(
   input wire logic clk_i,
   input wire logic [BUS_DW-1:0] rdata_i,
   input wire logic wait_i,
   output logic [BUS_AW-1:0] addr_o,
   output logic rd_o,
   output logic wr_o,
   output logic [BUS_DW-1:0] wdata_o
);
   // idle bus at time zero
   initial
   begin
      addr_o = 8'h00;
      rd_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = 32'h0;
   end
   // request held until waitrequest is seen low, data taken there
   task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d,
         output logic [7:0] q);
      @(posedge clk_i);
      addr_o <= {i, 2'h0};
      rd_o <= !w;
      wr_o <= w;
      wdata_o <= {24'h0, d};
      @(posedge clk_i);
      while (wait_i !== 1'b0)
         @(posedge clk_i);
      q = rdata_i[7:0];
      rd_o <= 1'b0;
      wr_o <= 1'b0;
   endtask
endmodule

//--- testbench.sv
// testbench: drives the host port through its register window
// assumes the host model owns the bus and the bench owns the ticks
`timescale 1ns/1ps
module testbench;
   import dhp_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic baud = 1'b0;
   logic btick = 1'b0;
   logic rx = 1'b0;
   logic rd, wr, wq, tx, irq_n;
   logic [BUS_AW-1:0] adr;
   logic [BUS_DW-1:0] wd, rdat;
   logic [7:0] q;
   logic [15:0] w;
   int err_total = 0;
   int checks = 0;
   always #10 clk_i = ~clk_i;
   dhp_host_port #(.SAMPLE_DIV(20)) dhp_host_port_i (.clk_i(clk_i), .rst_i(rst_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'h1), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
      .baud_tick_i(baud), .bit_tick_i(btick), .rx_bit_i(rx), .tx_bit_o(tx),
      .irq_n_o(irq_n));
   dhp_host_model dhp_host_model_i (.clk_i(clk_i), .rdata_i(rdat), .wait_i(wq),
      .addr_o(adr), .rd_o(rd), .wr_o(wr), .wdata_o(wd));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks++;
      if (s !== e)
      begin
         err_total++;
         $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
   endtask
   task automatic put(input logic [5:0] i, input logic [7:0] d);
      dhp_host_model_i.xfer(1'b1, i, d, q);
   endtask
   task automatic gc(input logic [5:0] i, input logic [7:0] e);
      dhp_host_model_i.xfer(1'b0, i, 8'h00, q);
      chk(q, e);
   endtask
   task automatic bitp(input logic b);
      @(posedge clk_i);
      btick <= 1'b1;
      rx <= b;
      @(posedge clk_i);
      btick <= 1'b0;
   endtask
   task automatic bpulse;
      @(posedge clk_i) baud <= 1'b1;
      @(posedge clk_i) baud <= 1'b0;
      repeat (3) @(negedge clk_i);
   endtask
   task automatic reset;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   task automatic summarize;
      if (err_total == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // watchdog
   initial
   begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      summarize();
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      reset();
      gc(6'h05, 8'h00);
      put(6'h3f, 8'h5a);
      gc(6'h3f, 8'h00);
      // one word into each bank by address bit seven
      for (int j = 0; j < 2; j++)
      begin
         w = j ? 16'h1234 : 16'habcd;
         put(6'h05, 8'h00);
         put(6'h04, {j[0], 7'h05});
         put(6'h05, 8'h1a);
         put(6'h01, w[15:8]);
         put(6'h00, w[7:0]);
         put(6'h05, 8'h1b);
         bpulse();
         gc(6'h05, 8'h7b);
         chk({7'h0, irq_n}, 8'h00);
         put(6'h00, w[7:0]);
         repeat (3) @(negedge clk_i);
         gc(6'h05, 8'h1b);
         chk({7'h0, irq_n}, 8'h01);
      end
      // read back both banks of location five
      put(6'h05, 8'h00);
      gc(6'h00, 8'h34);
      put(6'h04, 8'h05);
      put(6'h05, 8'h18);
      put(6'h05, 8'h19);
      repeat (50) @(negedge clk_i);
      gc(6'h05, 8'h19);
      bpulse();
      gc(6'h03, 8'hab);
      gc(6'h02, 8'hcd);
      gc(6'h01, 8'h12);
      gc(6'h00, 8'h34);
      repeat (3) @(negedge clk_i);
      gc(6'h05, 8'h19);
      chk({7'h0, irq_n}, 8'h01);
      // coefficient ram at location five, paced by the sample period
      put(6'h05, 8'h06);
      put(6'h01, 8'h5a);
      put(6'h00, 8'hc3);
      put(6'h05, 8'h07);
      repeat (30) @(negedge clk_i);
      gc(6'h05, 8'h67);
      put(6'h05, 8'h04);
      gc(6'h00, 8'hc3);
      put(6'h05, 8'h05);
      repeat (30) @(negedge clk_i);
      gc(6'h03, 8'h5a);
      gc(6'h02, 8'hc3);
      // programmable interrupt watching index 04, which holds 05
      put(6'h0a, 8'h04);
      for (int l = 0; l < 2; l++)
         for (int t = 0; t < 4; t++)
         begin
            put(6'h09, 8'h00);
            put(6'h0b, l ? 8'h02 : 8'h05);
            put(6'h09, {4'h0, t[1:0], l[0], 1'b1});
            repeat (60) @(negedge clk_i);
            dhp_host_model_i.xfer(1'b0, 6'h09, 8'h00, q);
            chk({7'h0, q[4]}, {7'h0, t == l});
            chk({7'h0, irq_n}, {7'h0, t != l});
         end
      // parallel receive, first byte overrun by the second
      put(6'h08, 8'h01);
      w = 16'hc51e;
      for (int k = 0; k < 16; k++)
         bitp(w[k]);
      repeat (3) @(negedge clk_i);
      gc(6'h15, 8'h60);
      gc(6'h10, 8'hc5);
      dhp_host_model_i.xfer(1'b0, 6'h15, 8'h00, q);
      chk(q & 8'h20, 8'h00);
      // parallel transmit after a fresh reset, no refill
      reset();
      put(6'h08, 8'h03);
      put(6'h10, 8'h3c);
      w = 16'h003c;
      for (int k = 1; k < 17; k++)
      begin
         bitp(1'b0);
         @(negedge clk_i);
         chk({7'h0, tx}, {7'h0, k < 8 ? 1'b0 : w[(k - 8) % 8]});
      end
      dhp_host_model_i.xfer(1'b0, 6'h15, 8'h00, q);
      chk(q & 8'h20, 8'h20);
      put(6'h10, 8'h3c);
      dhp_host_model_i.xfer(1'b0, 6'h15, 8'h00, q);
      chk(q & 8'h20, 8'h00);
      summarize();
   end
endmodule
